// file: bisr_asserts.sv
// Port checker for the burst idle spacing block
`timescale 1ns/10ps
module bisr_chk (
  input wire logic        mclk_i,        // Clock
  input wire logic        rstn_i,        // Reset
  input wire logic [7:0]  reg_addr_i,    // Address
  input wire logic [31:0] reg_wdata_i,   // Data
  input wire logic        reg_wr_i,      // Write
  input wire logic        reg_rd_i,      // Read
  input wire logic [31:0] reg_rdata_o,   // Read data
  input wire logic        bus32_strap_i, // Strap
  input wire logic [1:0]  cs_sel_i,      // Select
  input wire logic        burst_req_i,   // Request
  input wire logic        burst_go_o,    // Grant
  input wire logic        idle_o,        // Idle
  input wire logic        wide_bus_o,    // Width
  input wire logic [4:0]  max_beats_o    // Beats
);
  logic [3:0] spc_r;
  logic [2:0] tr_r;
  logic [3:0] icnt_r;
  logic       z1_r;
  logic       z2_r;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // Shadow the spacing and turnaround fields
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      spc_r <= 4'h0;
      tr_r  <= 3'h0;
    end else if (reg_wr_i && reg_addr_i == 8'h00) begin
      spc_r <= reg_wdata_i[3:0];
    end else if (reg_wr_i && reg_addr_i == 8'h01) begin
      tr_r <= reg_wdata_i[22:20];
    end
  end
  // Idle run length and how long spacing has been zero
  always_ff @(posedge mclk_i) begin
    icnt_r <= (rstn_i && idle_o) ? icnt_r + 4'h1 : 4'h0;
    z1_r   <= rstn_i && spc_r == 4'h0;
    z2_r   <= rstn_i && z1_r;
  end
  a_go_needs_req: assert property (
    burst_go_o |-> $past(burst_req_i)) else $error("grant without request");
  a_no_go_idle: assert property (
    burst_go_o |-> !idle_o) else $error("grant during idle");
  a_idle_len: assert property (
    $fell(idle_o) |-> icnt_r == ((tr_r == 3'h0) ? 4'h1 : {1'b0, tr_r}))
    else $error("idle length differs from turnaround");
  a_idle_short: assert property (
    idle_o [*7] |=> !idle_o) else $error("idle too long");
  a_zero_no_idle: assert property (
    spc_r == 4'h0 && z1_r && z2_r && !idle_o |=> !idle_o)
    else $error("idle with spacing zero");
  a_rdata_quiet: assert property (
    !reg_rd_i |=> reg_rdata_o == 32'h0) else $error("stray read data");
  a_beats_legal: assert property (
    max_beats_o inside {5'h01, 5'h04, 5'h08, 5'h10})
    else $error("bad beat limit");
  a_strap_width: assert property (
    (cs_sel_i == 2'h0 && bus32_strap_i) [*8] |=> wide_bus_o)
    else $error("strap ignored");
endmodule
bind bisr_top bisr_chk i_bisr_chk (.mclk_i, .rstn_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .bus32_strap_i,
  .cs_sel_i, .burst_req_i, .burst_go_o, .idle_o, .wide_bus_o, .max_beats_o);

// file: bisr_idle_seq.sv
// Burst counter and idle insertion sequencer
`timescale 1ns/10ps
module bisr_idle_seq (
  input  wire logic       mclk_i,        // Controller clock
  input  wire logic       rstn_i,        // Sync reset, active low
  input  wire logic [3:0] spacing_i,     // Bursts allowed back to back
  input  wire logic [2:0] tr_cycles_i,   // Idle length in cycles
  input  wire logic       burst_req_i,   // Request to start a burst
  input  wire logic       burst_done_i,  // Current burst finished
  output logic            burst_go_o,    // Burst may start this cycle
  output logic            idle_o,        // Idle period running
  output logic [3:0]      count_o        // Bursts run since last idle
);
  typedef enum {S_RUN, S_IDLE} bisr_seq_t;
  bisr_seq_t  st_r;
  logic [3:0] cnt_r;
  logic [2:0] idle_cnt_r;
  logic       limit_hit;
  logic       go_q_r;

  // Limit reached once count reaches or exceeds a nonzero spacing value
  assign limit_hit = (spacing_i != bisr_pkg::CNT_ZERO) &&
                     (cnt_r >= spacing_i);
  // The request still stands the cycle after a grant; do not grant it twice
  assign burst_go_o = (st_r == S_RUN) && burst_req_i && !limit_hit &&
                      !go_q_r;
  assign idle_o     = (st_r == S_IDLE);
  assign count_o    = cnt_r;

  // Sequencer state and counters
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st_r       <= S_RUN;
      cnt_r      <= bisr_pkg::CNT_ZERO;
      idle_cnt_r <= bisr_pkg::IDLE_CNT_RST;
    end else begin
      case (st_r)
        S_RUN: begin
          if (burst_done_i && cnt_r != bisr_pkg::CNT_MAX) begin
            cnt_r <= cnt_r + bisr_pkg::CNT_ONE;
          end
          if (limit_hit && burst_req_i && !go_q_r) begin
            st_r       <= S_IDLE;
            idle_cnt_r <= (tr_cycles_i == 3'h0) ? bisr_pkg::TR_ONE
                                                : tr_cycles_i;
          end
        end
        S_IDLE: begin
          if (idle_cnt_r <= bisr_pkg::TR_ONE) begin
            st_r  <= S_RUN;
            cnt_r <= bisr_pkg::CNT_ZERO;
          end else begin
            idle_cnt_r <= idle_cnt_r - bisr_pkg::TR_ONE;
          end
        end
        default: st_r <= S_RUN;
      endcase
    end
  end

  // Grant of the previous cycle, masks the request it already served
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      go_q_r <= 1'b0;
    end else begin
      go_q_r <= burst_go_o;
    end
  end
endmodule

// file: bisr_mem_model.sv
// Far side memory: ends each granted burst after a delay
`timescale 1ns/10ps
module bisr_mem_model (
  input  wire logic       mclk_i, // Clock
  input  wire logic       go_i,   // Burst granted
  input  wire logic [3:0] lat_i,  // Cycles to finish
  output logic            done_o  // Burst done pulse
);
  logic [3:0] left_r = 4'h0;
  initial done_o = 1'b0;
  // Count down the burst, pulse done on its last cycle
  always @(posedge mclk_i) begin
    if (go_i) left_r <= lat_i;
    else if (left_r != 4'h0) left_r <= left_r - 4'h1;
    done_o <= !go_i && left_r == 4'h1;
  end
endmodule

// file: bisr_pkg.sv
// Package for the burst idle spacing and readback block
package bisr_pkg;
  // Register indices within the local register port (word addresses)
  localparam logic [7:0] ADDR_SPACING = 8'h00;
  localparam logic [7:0] ADDR_CYCLES  = 8'h01;
  localparam logic [7:0] ADDR_MODE    = 8'h02;
  localparam logic [7:0] ADDR_STATUS  = 8'h03;
  localparam logic [7:0] ADDR_CYC_RB0 = 8'h10;
  localparam logic [7:0] ADDR_MODE_RB0 = 8'h20;
  // Mode readback placement in the system map
  localparam logic [31:0] MODE_RB_BASE   = 32'h400A8018;
  localparam logic [31:0] MODE_RB_STRIDE = 32'h00000020;
  localparam int          NUM_CS         = 4;
  // Field positions
  localparam int SPACING_W  = 4;
  localparam int TR_LSB     = 20;
  localparam int TR_W       = 3;
  localparam int WIDTH_LSB  = 0;
  localparam int RDBL_LSB   = 3;
  localparam int MODE_W     = 16;
  localparam int WEXT_BIT   = 0;
  localparam int ADMUX_BIT  = 1;
  // Encodings
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;
  localparam logic [2:0] BL_SINGLE = 3'h0;
  localparam logic [2:0] BL_4      = 3'h1;
  localparam logic [2:0] BL_8      = 3'h2;
  localparam logic [2:0] BL_16     = 3'h3;
  // Reset values
  localparam logic [3:0]  SPACING_RST = 4'h0;
  localparam logic [31:0] CYCLES_RST  = 32'h00000000;
  localparam logic [15:0] OPMODE_RST  = 16'h0001;
  localparam logic [1:0]  CTRL_RST    = 2'h0;
  localparam logic [2:0]  IDLE_CNT_RST = 3'h0;
  localparam logic [4:0]  BEATS_RST   = 5'h01;
  // Counting
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE  = 4'h1;
  localparam logic [3:0] CNT_MAX  = 4'hF;
  localparam logic [2:0] TR_ONE   = 3'h1;
endpackage

// file: bisr_top.sv
// Burst idle spacing with per chip select readback registers
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module bisr_top (
  input  wire logic        mclk_i,        // Controller clock, 20 MHz
  input  wire logic        rstn_i,        // Sync reset, active low
  input  wire logic [7:0]  reg_addr_i,    // Register word index
  input  wire logic [31:0] reg_wdata_i,   // Register write data
  input  wire logic        reg_wr_i,      // Write strobe
  input  wire logic        reg_rd_i,      // Read strobe
  output logic [31:0]      reg_rdata_o,   // Read data, cycle after strobe
  input  wire logic        bus32_strap_i, // Width strap pin for CS0
  input  wire logic [1:0]  cs_sel_i,      // Chip select of next burst
  input  wire logic        burst_req_i,   // Burst requested by bus side
  input  wire logic        burst_done_i,  // Current burst finished
  output logic             burst_go_o,    // Burst start granted
  output logic             idle_o,        // Idle period running
  output logic             wide_bus_o,    // 32 bit bus for selected CS
  output logic [4:0]       max_beats_o,   // Read burst beat limit
  output logic             mode_err_o     // Prohibited mode setting seen
);
  logic [3:0]  spacing_r;
  logic [31:0] cycles_r;
  logic [15:0] opmode_r;
  logic [1:0]  ctrl_r;
  logic [31:0] cyc_rb_r [bisr_pkg::NUM_CS];
  logic [15:0] mode_rb_r [bisr_pkg::NUM_CS];
  logic [2:0]  strap_sync_r;
  logic        strap_r;
  logic        go_w;
  logic        idle_w;
  logic [3:0]  cnt_w;
  logic [31:0] rdata_nxt;
  logic [15:0] sel_mode;
  logic [1:0]  sel_width;
  logic [2:0]  sel_bl;

  // Spacing register, low four bits used
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      spacing_r <= bisr_pkg::SPACING_RST;
    end else if (reg_wr_i && reg_addr_i == bisr_pkg::ADDR_SPACING) begin
      spacing_r <= reg_wdata_i[bisr_pkg::SPACING_W-1:0];
    end
  end

  // Timing, mode and control configuration
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      cycles_r <= bisr_pkg::CYCLES_RST;
      opmode_r <= bisr_pkg::OPMODE_RST;
      ctrl_r   <= bisr_pkg::CTRL_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == bisr_pkg::ADDR_CYCLES) begin
        cycles_r <= reg_wdata_i;
      end
      if (reg_addr_i == bisr_pkg::ADDR_MODE) begin
        opmode_r <= reg_wdata_i[bisr_pkg::MODE_W-1:0];
      end
      if (reg_addr_i == bisr_pkg::ADDR_STATUS) begin
        ctrl_r <= reg_wdata_i[1:0];
      end
    end
  end

  // Per chip select copies taken on a burst start; no reset (undefined)
  genvar g;
  generate
    for (g = 0; g < bisr_pkg::NUM_CS; g++) begin : g_rb
      always_ff @(posedge mclk_i) begin
        if (go_w && cs_sel_i == 2'(g)) begin
          cyc_rb_r[g]  <= cycles_r;
          mode_rb_r[g] <= opmode_r;
        end
      end
    end
  endgenerate

  // Strap pin passes three flops; change taken when last two agree
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      strap_sync_r <= 3'h0;
      strap_r      <= 1'b0;
    end else begin
      strap_sync_r <= {strap_sync_r[1:0], bus32_strap_i};
      if (strap_sync_r[1] == strap_sync_r[2]) begin
        strap_r <= strap_sync_r[2];
      end
    end
  end

  bisr_idle_seq i_bisr_idle_seq (
    .mclk_i       (mclk_i),
    .rstn_i       (rstn_i),
    .spacing_i    (spacing_r),
    .tr_cycles_i  (cycles_r[bisr_pkg::TR_LSB +: bisr_pkg::TR_W]),
    .burst_req_i  (burst_req_i),
    .burst_done_i (burst_done_i),
    .burst_go_o   (go_w),
    .idle_o       (idle_w),
    .count_o      (cnt_w)
  );

  // Decode of the live mode for the selected chip select
  always_comb begin
    sel_mode = opmode_r;
    sel_width = sel_mode[bisr_pkg::WIDTH_LSB +: 2];
    sel_bl   = sel_mode[bisr_pkg::RDBL_LSB +: 3];
  end

  // Burst grant, width and beat limit outputs
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      burst_go_o  <= 1'b0;
      idle_o      <= 1'b0;
      wide_bus_o  <= 1'b0;
      max_beats_o <= bisr_pkg::BEATS_RST;
      mode_err_o  <= 1'b0;
    end else begin
      burst_go_o <= go_w;
      idle_o     <= idle_w;
      if (cs_sel_i == 2'h0) begin
        wide_bus_o <= strap_r;
      end else begin
        wide_bus_o <= (sel_width == bisr_pkg::WIDTH_32);
      end
      case (sel_bl)
        bisr_pkg::BL_SINGLE: max_beats_o <= 5'h01;
        bisr_pkg::BL_4:      max_beats_o <= 5'h04;
        bisr_pkg::BL_8:      max_beats_o <= 5'h08;
        bisr_pkg::BL_16:     max_beats_o <= 5'h10;
        default:             max_beats_o <= 5'h01;
      endcase
      mode_err_o <= (sel_bl > bisr_pkg::BL_16) ||
                    (cs_sel_i != 2'h0 && sel_width != bisr_pkg::WIDTH_16 &&
                     sel_width != bisr_pkg::WIDTH_32);
    end
  end

  // Read mux; unmapped indices read zero
  always_comb begin
    rdata_nxt = 32'h00000000;
    case (reg_addr_i)
      bisr_pkg::ADDR_SPACING: rdata_nxt = {28'h0000000, spacing_r};
      bisr_pkg::ADDR_CYCLES:  rdata_nxt = cycles_r;
      bisr_pkg::ADDR_MODE:    rdata_nxt = {16'h0000, opmode_r};
      bisr_pkg::ADDR_STATUS:  rdata_nxt = {24'h000000, cnt_w, idle_w,
                                           strap_r, ctrl_r};
      default: begin
        if (reg_addr_i[7:2] == bisr_pkg::ADDR_CYC_RB0[7:2]) begin
          rdata_nxt = cyc_rb_r[reg_addr_i[1:0]];
        end else if (reg_addr_i[7:2] == bisr_pkg::ADDR_MODE_RB0[7:2]) begin
          rdata_nxt = {16'h0000, mode_rb_r[reg_addr_i[1:0]]};
        end
      end
    endcase
  end

  // Read data register, valid in the cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end
endmodule

// file: test_burst_idle_spacing_readback.sv
// Testbench for burst idle spacing and readback
`timescale 1ns/10ps
module test_burst_idle_spacing_readback;
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        bus32_strap_i = 1'b0;
  logic [1:0]  cs_sel_i = 2'h0;
  logic        burst_req_i = 1'b0;
  logic [3:0]  lat = 4'h1;
  logic [31:0] reg_rdata_o;
  logic        burst_done_i;
  logic        burst_go_o;
  logic        idle_o;
  logic        wide_bus_o;
  logic        mode_err_o;
  logic [4:0]  max_beats_o;
  int          n_mismatch = 0;
  int          check_count = 0;
  bisr_top i_bisr_top (.mclk_i, .rstn_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .bus32_strap_i, .cs_sel_i,
    .burst_req_i, .burst_done_i, .burst_go_o, .idle_o, .wide_bus_o,
    .max_beats_o, .mode_err_o);
  bisr_mem_model i_bisr_mem_model (.mclk_i, .go_i(burst_go_o),
    .lat_i(lat), .done_o(burst_done_i));
  initial forever #25 mclk_i = ~mclk_i;
  // Verdict and end of run
  task automatic end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(negedge mclk_i);
    chk(reg_rdata_o, e);
  endtask
  // One burst: count idle cycles seen before the grant
  task automatic burst(output int idl);
    int i;
    idl = 0;
    @(posedge mclk_i);
    burst_req_i <= 1'b1;
    for (i = 0; i < 40 && burst_go_o !== 1'b1; i++) begin
      @(negedge mclk_i);
      if (idle_o === 1'b1 && burst_go_o !== 1'b1) idl++;
    end
    @(posedge mclk_i);
    burst_req_i <= 1'b0;
    for (i = i; i < 80 && burst_done_i !== 1'b1; i++) @(negedge mclk_i);
    if (i >= 80) begin
      n_mismatch++;
      $display("unexpected at %0t: burst timed out", $time);
      end_of_test();
    end
    @(posedge mclk_i);
  endtask
  // Reset values, burst length codes, width field and strap
  task automatic t_mode;
    int e;
    rd(8'h02, {16'h0, bisr_pkg::OPMODE_RST});
    chk({23'h0, burst_go_o, idle_o, wide_bus_o, mode_err_o, max_beats_o},
      32'h1);
    rd(8'h7F, 32'h0);
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'h0000000F);
    @(posedge mclk_i);
    cs_sel_i <= 2'h1;
    for (e = 0; e < 5; e++) begin
      wr(8'h02, 32'(e * 8 + 1));
      repeat (3) @(negedge mclk_i);
      chk({31'h0, mode_err_o}, {31'h0, e == 4});
      if (e < 4) chk({27'h0, max_beats_o}, 32'(e == 0 ? 1 : 2 << e));
    end
    wr(8'h02, 32'h2);
    repeat (3) @(negedge mclk_i);
    chk({30'h0, wide_bus_o, mode_err_o}, 32'h2);
    wr(8'h02, 32'h3);
    repeat (3) @(negedge mclk_i);
    chk({31'h0, mode_err_o}, 32'h1);
    @(posedge mclk_i);
    cs_sel_i      <= 2'h0;
    bus32_strap_i <= 1'b1;
    repeat (12) @(negedge mclk_i);
    chk({31'h0, wide_bus_o}, 32'h1);
    wr(8'h03, 32'h1);
    wr(8'h00, 32'h1);
    rd(8'h03, 32'h5);
  endtask
  // Spacing n, turnaround t: idle after every nth burst only
  task automatic t_spacing(input logic [3:0] n, input logic [2:0] t);
    int k;
    int idl;
    @(posedge mclk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    wr(8'h01, {9'h0, t, 20'h0});
    wr(8'h00, {28'h0, n});
    for (k = 0; k < 2 * n + 3; k++) begin
      lat      <= 4'(k % 3 + 1);
      cs_sel_i <= k[1:0];
      burst(idl);
      chk(32'(idl), (n != 0 && k != 0 && k % n == 0) ?
        ((t == 3'h0) ? 32'h1 : 32'(t)) : 32'h0);
    end
    wr(8'h10 + 8'(cs_sel_i), 32'hFFFFFFFF);
    rd(8'h10 + 8'(cs_sel_i), {9'h0, t, 20'h0});
    rd(8'h20 + 8'(cs_sel_i), {16'h0, bisr_pkg::OPMODE_RST});
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_mode();
    t_spacing(4'h0, 3'h2);
    t_spacing(4'h1, 3'h0);
    t_spacing(4'h2, 3'h3);
    t_spacing(4'hF, 3'h7);
    end_of_test();
  end
endmodule
